/* File: shared/acr_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
//          for the channel configuration register slice.
// Assumes: Plain register port, 8-bit data, page 0 only.
// Notes:   Definitions only.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------
// Page and offsets
// ----------------------------------------
`define ACR_PAGE_ZERO 8'h00
`define ACR_OFF_PHASE 8'h45
`define ACR_OFF_INCFG 8'h46
`define ACR_OFF_GAIN 8'h47
`define ACR_OFF_VOL 8'h48
`define ACR_OFF_TRIM 8'h49

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACR_KIND_BIT 7
`define ACR_SRC_HI 6
`define ACR_SRC_LO 5
`define ACR_CPL_BIT 4
`define ACR_IMP_HI 3
`define ACR_IMP_LO 2
`define ACR_BOOST_BIT 0
`define ACR_GAIN_HI 7
`define ACR_GAIN_LO 2
`define ACR_TRIM_HI 7
`define ACR_TRIM_LO 4

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define ACR_MASK_INCFG 8'hFD
`define ACR_MASK_GAIN 8'hFC
`define ACR_MASK_TRIM 8'hF0
`define ACR_RST_PHASE 8'h00
`define ACR_RST_INCFG 8'h00
`define ACR_RST_GAIN 8'h00
`define ACR_RST_VOL 8'hC9
`define ACR_RST_TRIM 8'h80

// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define ACR_VOL_MUTE 8'h00
`define ACR_TRIM_ZERO 4'h8
`define ACR_GAIN_MAX 6'h2A
`define ACR_DLY_DEPTH 255
`define ACR_MOD_DIV 20

`endif

/* File: shared/acr_pkg.sv */
// Purpose: Types for the channel configuration register slice.
// Assumes: Offsets and constants live in acr_map.svh.
// Notes:   Encodings follow the register field codes.
package acr_pkg;

  // Channel input source codes
  typedef enum logic [1:0] {
    ACR_SRC_DIFF,
    ACR_SRC_SINGLE,
    ACR_SRC_PDM,
    ACR_SRC_RSVD
  } acr_src_t;

  // Analog input impedance codes
  typedef enum logic [1:0] {
    ACR_IMP_2K5,
    ACR_IMP_10K,
    ACR_IMP_20K,
    ACR_IMP_RSVD
  } acr_imp_t;

  typedef logic [7:0] acr_byte_t;

endpackage

/* File: shared/acr_delay_if.sv */
// Purpose: Carrier between the register slice and the phase delay line.
// Assumes: Single clock; mod_en is a one-cycle enable.
// Notes:   ctl drives, dly answers.
`timescale 1ns/1ps
interface acr_delay_if;
  logic mod_en;
  logic din;
  logic [7:0] code;
  logic dout;

  modport ctl (output mod_en, output din, output code, input dout);
  modport dly (input mod_en, input din, input code, output dout);
endinterface : acr_delay_if

/* File: verilog/acr_phase_delay.sv */
// Purpose: Programmable delay of a modulator bit stream, 0..255 steps.
// Assumes: One step per modulator enable pulse.
// Notes:   Code 0 passes the stream with only the output register.
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_phase_delay #(
  parameter int DEPTH = `ACR_DLY_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  acr_delay_if.dly dl
);
  import acr_pkg::*;

  // ----------------------------------------
  // Delay line storage
  // ----------------------------------------
  logic line_r [DEPTH];
  logic dout_r;
  logic tap_sel;

  // Tap N-1 holds the sample N steps old
  assign tap_sel = (dl.code == 8'h00) ? dl.din : line_r[dl.code - 8'h01];
  assign dl.dout = dout_r;

  // Head of the line
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_r[0] <= 1'b0;
    end else if (dl.mod_en) begin
      line_r[0] <= dl.din;
    end
  end

  // One shift stage per entry
  genvar gi;
  generate
    for (gi = 1; gi < DEPTH; gi++) begin : g_stage
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          line_r[gi] <= 1'b0;
        end else if (dl.mod_en) begin
          line_r[gi] <= line_r[gi-1];
        end
      end
    end
  endgenerate

  // Registered tap output
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dout_r <= 1'b0;
    end else if (dl.mod_en) begin
      dout_r <= tap_sel;
    end
  end

endmodule // acr_phase_delay

/* File: verilog/acr_regs.sv */
// Purpose: Channel-2 phase delay and channel-3 configuration registers.
// Assumes: Plain register port; read data in the cycle after the strobe.
// Notes:   Decoded settings leave through registered outputs.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_regs #(
  parameter int MOD_DIV = `ACR_MOD_DIV,
  parameter int DLY_DEPTH = `ACR_DLY_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] page_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic page0_reg_108_bit3_in,
  input wire logic ch2_mod_data_in,
  output logic [7:0] rdata_out,
  output logic ch2_delayed_out,
  output logic ch3_input_kind_out,
  output acr_pkg::acr_src_t ch3_source_select_out,
  output logic ch3_pdm_select_out,
  output logic ch3_coupling_select_out,
  output acr_pkg::acr_imp_t ch3_impedance_select_out,
  output logic dynamic_range_enhancer_en_out,
  output logic automatic_gain_loop_en_out,
  output logic [5:0] code_a_out,
  output logic ch3_mute_out,
  output logic signed [8:0] ch3_volume_half_db_out,
  output logic signed [4:0] ch3_trim_tenth_db_out,
  output logic reserved_code_out
);
  import acr_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  acr_byte_t phase_r;
  acr_byte_t incfg_r;
  acr_byte_t gain_r;
  acr_byte_t vol_r;
  acr_byte_t trim_r;
  acr_byte_t rdata_r;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic page_hit;
  logic hit_phase;
  logic hit_incfg;
  logic hit_gain;
  logic hit_vol;
  logic hit_trim;
  logic we_phase;
  logic we_incfg;
  logic we_gain;
  logic we_vol;
  logic we_trim;

  // Only page 0 holds this slice
  assign page_hit = (page_in == `ACR_PAGE_ZERO);

  assign hit_phase = page_hit && (addr_in == `ACR_OFF_PHASE);

  assign hit_incfg = page_hit && (addr_in == `ACR_OFF_INCFG);
  assign hit_gain = page_hit && (addr_in == `ACR_OFF_GAIN);
  assign hit_vol = page_hit && (addr_in == `ACR_OFF_VOL);
  assign hit_trim = page_hit && (addr_in == `ACR_OFF_TRIM);

  // Write enables per register
  assign we_phase = wr_in && hit_phase;
  assign we_incfg = wr_in && hit_incfg;
  assign we_gain = wr_in && hit_gain;
  assign we_vol = wr_in && hit_vol;
  assign we_trim = wr_in && hit_trim;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------

  // Phase code, reset to no delay
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_r <= `ACR_RST_PHASE;
    end else if (we_phase) begin
      phase_r <= wdata_in;
    end
  end

  // Input config drops reserved bit 1
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      incfg_r <= `ACR_RST_INCFG;
    end else if (we_incfg) begin
      incfg_r <= wdata_in & `ACR_MASK_INCFG;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_r <= `ACR_RST_GAIN;
    end else if (we_gain) begin
      gain_r <= wdata_in & `ACR_MASK_GAIN;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vol_r <= `ACR_RST_VOL;
    end else if (we_vol) begin
      vol_r <= wdata_in;
    end
  end

  // Trim resets to zero offset, low nibble dropped
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trim_r <= `ACR_RST_TRIM;
    end else if (we_trim) begin
      trim_r <= wdata_in & `ACR_MASK_TRIM;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  acr_byte_t rd_mux;

  // Unmapped and reserved read as zero
  assign rd_mux = hit_phase ? phase_r :
                  hit_incfg ? incfg_r :
                  hit_gain ? gain_r :
                  hit_vol ? vol_r :
                  hit_trim ? trim_r : 8'h00;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_in ? rd_mux : 8'h00;
    end
  end

  assign rdata_out = rdata_r;

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  logic kind_f;
  acr_src_t src_f;
  logic cpl_f;
  acr_imp_t imp_f;
  logic boost_f;
  logic [5:0] gain_f;
  logic [3:0] trim_f;
  logic src_analog;

  assign kind_f = incfg_r[`ACR_KIND_BIT];
  assign src_f = acr_src_t'(incfg_r[`ACR_SRC_HI:`ACR_SRC_LO]);
  assign cpl_f = incfg_r[`ACR_CPL_BIT];
  assign imp_f = acr_imp_t'(incfg_r[`ACR_IMP_HI:`ACR_IMP_LO]);
  assign boost_f = incfg_r[`ACR_BOOST_BIT];
  assign gain_f = gain_r[`ACR_GAIN_HI:`ACR_GAIN_LO];
  assign trim_f = trim_r[`ACR_TRIM_HI:`ACR_TRIM_LO];
  assign src_analog = (src_f == ACR_SRC_DIFF) || (src_f == ACR_SRC_SINGLE);

  // ----------------------------------------
  // Decoded settings, next values
  // ----------------------------------------
  logic pdm_nxt;
  logic cpl_nxt;
  acr_imp_t imp_nxt;
  logic dre_nxt;
  logic agc_nxt;
  logic mute_nxt;
  logic [8:0] vol_nxt;
  logic [4:0] trim_nxt;
  logic rsvd_nxt;

  // Analog pick assumes software freed the shared pins
  // PDM pick assumes software routed the PDM pins
  assign pdm_nxt = (src_f == ACR_SRC_PDM);

  assign cpl_nxt = cpl_f && src_analog;

  assign imp_nxt = src_analog ? imp_f : ACR_IMP_2K5;

  // Enable steered by register 108 bit 3
  assign dre_nxt = boost_f && !page0_reg_108_bit3_in;
  assign agc_nxt = boost_f && page0_reg_108_bit3_in;

  assign mute_nxt = (vol_r == `ACR_VOL_MUTE);

  // Half-dB steps about the unity code
  assign vol_nxt = {1'b0, vol_r} - {1'b0, `ACR_RST_VOL};

  assign trim_nxt = {1'b0, trim_f} - {1'b0, `ACR_TRIM_ZERO};

  // Reserved gain, source or impedance codes flagged
  assign rsvd_nxt = (gain_f > `ACR_GAIN_MAX) ||
                    (src_f == ACR_SRC_RSVD) ||
                    (imp_f == ACR_IMP_RSVD);

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic kind_r;
  acr_src_t src_r;
  logic pdm_r;
  logic cpl_r;
  acr_imp_t imp_r;
  logic dre_r;
  logic agc_r;
  logic [5:0] gain_out_r;
  logic mute_r;
  logic signed [8:0] vol_db_r;
  logic signed [4:0] trim_db_r;
  logic rsvd_r;

  // Source and coupling settings
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      kind_r <= 1'b0;
      src_r <= ACR_SRC_DIFF;
      pdm_r <= 1'b0;
      cpl_r <= 1'b0;
      imp_r <= ACR_IMP_2K5;
    end else begin
      kind_r <= kind_f;
      src_r <= src_f;
      pdm_r <= pdm_nxt;
      cpl_r <= cpl_nxt;
      imp_r <= imp_nxt;
    end
  end

  // Gain, volume and range settings
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dre_r <= 1'b0;
      agc_r <= 1'b0;
      gain_out_r <= 6'h00;
      mute_r <= 1'b0;
      vol_db_r <= 9'h000;
      trim_db_r <= 5'h00;
      rsvd_r <= 1'b0;
    end else begin
      dre_r <= dre_nxt;
      agc_r <= agc_nxt;
      gain_out_r <= gain_f;
      mute_r <= mute_nxt;
      vol_db_r <= vol_nxt;
      trim_db_r <= trim_nxt;
      rsvd_r <= rsvd_nxt;
    end
  end

  assign ch3_input_kind_out = kind_r;
  assign ch3_source_select_out = src_r;
  assign ch3_pdm_select_out = pdm_r;
  assign ch3_coupling_select_out = cpl_r;
  assign ch3_impedance_select_out = imp_r;
  assign dynamic_range_enhancer_en_out = dre_r;
  assign automatic_gain_loop_en_out = agc_r;
  assign code_a_out = gain_out_r;
  assign ch3_mute_out = mute_r;
  assign ch3_volume_half_db_out = vol_db_r;
  assign ch3_trim_tenth_db_out = trim_db_r;
  assign reserved_code_out = rsvd_r;

  // ----------------------------------------
  // Modulator rate divider
  // ----------------------------------------
  localparam int DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic div_wrap;
  logic mod_en_r;

  assign div_wrap = (div_r == DIV_LAST);
  assign div_nxt = div_wrap ? '0 : div_r + DIV_W'(1);

  // One enable pulse per modulator cycle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= '0;
      mod_en_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      mod_en_r <= div_wrap;
    end
  end

  // ----------------------------------------
  // Channel-2 phase delay
  // ----------------------------------------
  acr_delay_if dly_if ();

  // Delay steps taken from the phase code
  assign dly_if.mod_en = mod_en_r;
  assign dly_if.din = ch2_mod_data_in;
  assign dly_if.code = phase_r;

  acr_phase_delay #(
    .DEPTH(DLY_DEPTH)
  ) u_phase_delay (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .dl(dly_if.dly)
  );

  assign ch2_delayed_out = dly_if.dout;

endmodule // acr_regs

/* File: test/acr_regs_chk.sv */
// Purpose: Port-level checks on the channel configuration slice.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to acr_regs at the foot of this file.
`timescale 1ns/1ps
module acr_regs_chk #(
  parameter int MOD_DIV = 20,
  parameter int DLY_DEPTH = 255
) (
  input logic sys_clk_in,
  input logic rstn_in,
  input logic [7:0] page_in,
  input logic [7:0] addr_in,
  input logic [7:0] wdata_in,
  input logic wr_in,
  input logic rd_in,
  input logic [7:0] rdata_out,
  input logic ch3_input_kind_out,
  input acr_pkg::acr_src_t ch3_source_select_out,
  input logic ch3_pdm_select_out,
  input logic dynamic_range_enhancer_en_out,
  input logic automatic_gain_loop_en_out,
  input logic [5:0] code_a_out,
  input logic ch3_mute_out,
  input logic signed [8:0] ch3_volume_half_db_out,
  input logic signed [4:0] ch3_trim_tenth_db_out
);
  import acr_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // Page-0 write decode and expected field values
  wire [7:0] wr_hit = (wr_in && page_in == 8'h00) ? addr_in : 8'h00;
  wire signed [8:0] vol_exp = $signed({1'b0, wdata_in}) - 9'sd201;
  wire signed [4:0] trim_exp = $signed({1'b0, wdata_in[7:4]}) - 5'sd8;
  wire [2:0] kind_src = wdata_in[7:5];

  a_page_refuse: assert property (rd_in && page_in != 8'h00 |=> rdata_out == 8'h00)
    else $error("read of another page returned data");
  a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_mute_code: assert property (wr_hit == 8'h48 && wdata_in == 8'h00 |-> ##2 ch3_mute_out)
    else $error("volume code zero did not mute");
  a_volume_map: assert property (wr_hit == 8'h48 && wdata_in != 8'h00 |-> ##2
    !ch3_mute_out && ch3_volume_half_db_out == $past(vol_exp, 2))
    else $error("volume step value wrong");
  a_gain_code: assert property (wr_hit == 8'h47 |-> ##2 code_a_out == ($past(wdata_in, 2) >> 2))
    else $error("gain code not taken from bits 7-2");
  a_trim_map: assert property (wr_hit == 8'h49 |-> ##2 ch3_trim_tenth_db_out == $past(trim_exp, 2))
    else $error("trim offset wrong");
  a_input_map: assert property (wr_hit == 8'h46 |-> ##2
    {ch3_input_kind_out, ch3_source_select_out} == $past(kind_src, 2))
    else $error("input kind or source wrong");
  a_enable_excl: assert property (!(dynamic_range_enhancer_en_out && automatic_gain_loop_en_out))
    else $error("both gain engines enabled");
  a_pdm_flag: assert property (ch3_pdm_select_out == (ch3_source_select_out == ACR_SRC_PDM))
    else $error("PDM flag disagrees with source");
  a_reset_state: assert property ($rose(rstn_in) |-> ch3_volume_half_db_out == 9'sd0 &&
    ch3_trim_tenth_db_out == 5'sd0 && rdata_out == 8'h00)
    else $error("volume or trim not at reset code");
endmodule // acr_regs_chk

bind acr_regs acr_regs_chk #(.MOD_DIV(MOD_DIV), .DLY_DEPTH(DLY_DEPTH)) u_chk (.sys_clk_in,
  .rstn_in, .page_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .ch3_input_kind_out,
  .ch3_source_select_out, .ch3_pdm_select_out, .dynamic_range_enhancer_en_out,
  .automatic_gain_loop_en_out, .code_a_out, .ch3_mute_out, .ch3_volume_half_db_out,
  .ch3_trim_tenth_db_out);

/* File: test/adc_channel_config_regs_tb_top.sv */
// Purpose: Self-checking bench for the channel configuration slice.
// Assumes: Modulator divider shortened to 2 to keep delay runs brief.
// Notes:   Read results are checked against a queue of expected bytes.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module adc_channel_config_regs_tb_top;
  import acr_pkg::*;
  localparam int DIV = 2;
  localparam logic [7:0] MSK [5] = '{8'hFF, 8'hFD, 8'hFC, 8'hFF, 8'hF0};
  localparam logic [7:0] RST [5] = '{8'h00, 8'h00, 8'h00, 8'hC9, 8'h80};
  localparam int PC [4] = '{0, 1, 3, 255};
  logic sys_clk_in, rstn_in, wr, rd, rd_d, r108, dat, dly, pdm, cpl, dynamic_range_enhancer, automatic_gain_loop, rsv, mute;
  logic [7:0] page, addr, wdata, rdata, d, exp_v;
  logic [7:0] mdl [5];
  logic [1:0] src;
  acr_imp_t imp;
  logic [7:0] exp_q [$];
  int n_mismatch = 0, checks = 0, seed = 63, i, k, n;

  acr_regs #(.MOD_DIV(DIV)) dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .page_in(page),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .page0_reg_108_bit3_in(r108),
    .ch2_mod_data_in(dat), .rdata_out(rdata), .ch2_delayed_out(dly), .ch3_input_kind_out(),
    .ch3_source_select_out(), .ch3_pdm_select_out(pdm), .ch3_coupling_select_out(cpl),
    .ch3_impedance_select_out(imp), .dynamic_range_enhancer_en_out(dynamic_range_enhancer),
    .automatic_gain_loop_en_out(automatic_gain_loop), .code_a_out(), .ch3_mute_out(mute),
    .ch3_volume_half_db_out(), .ch3_trim_tenth_db_out(), .reserved_code_out(rsv));

  // Clock, 8 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // One bus cycle; reads note their expected byte
  task automatic acc(input logic w, input logic [7:0] p, a, v, e);
    @(posedge sys_clk_in);
    page <= p;
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(e);
    @(posedge sys_clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Let decoded outputs land
  task automatic settle();
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read data monitor, one cycle after the strobe
  always @(posedge sys_clk_in) rd_d <= rd;
  always @(negedge sys_clk_in) begin
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  end

  // Watchdog
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    {wr, rd, r108, dat, page, addr, wdata} = '0;
    rstn_in = 1'b0;
    mdl = RST;
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    for (i = 0; i < 5; i++) acc(0, 0, 8'(8'h45 + i), 0, RST[i]);
    for (i = 0; i < 40; i++) begin
      k = $unsigned($random(seed)) % 5;
      d = 8'($random(seed));
      acc(1, 0, 8'(8'h45 + k), d, 0);
      mdl[k] = d & MSK[k];
      acc(0, 0, 8'(8'h45 + k), 0, mdl[k]);
    end
    acc(1, 8'h01, 8'h48, 8'h00, 0);
    acc(0, 0, 8'h48, 0, mdl[3]);
    acc(0, 8'h01, 8'h48, 0, 0);
    acc(0, 0, 8'h44, 0, 0);
    acc(0, 0, 8'h4A, 0, 0);
    // Mid-run reset over written values brings the defaults back
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    for (i = 0; i < 5; i++) acc(0, 0, 8'(8'h45 + i), 0, RST[i]);
    foreach (RST[j]) begin
      d = (j == 0) ? 8'h00 : (j == 1) ? 8'h01 : (j == 2) ? 8'hC9 : 8'hFF;
      acc(1, 0, 8'h48, d, 0);
      settle();
      `CHK(mute, d == 8'h00)
    end
    // shared pins taken as already routed by software before each pick
    for (i = 0; i < 8; i++) begin
      src = i[1:0];
      @(posedge sys_clk_in);
      r108 <= i[2];
      acc(1, 0, 8'h46, {1'b1, src, 5'b11101}, 0);
      settle();
      `CHK(cpl, src < 2)
      `CHK(imp, src < 2 ? ACR_IMP_RSVD : ACR_IMP_2K5)
      `CHK(pdm, src == 2)
      `CHK({dynamic_range_enhancer, automatic_gain_loop}, {!i[2], i[2]})
      `CHK(rsv, 1'b1)
    end
    acc(1, 0, 8'h46, 8'h00, 0);
    for (i = 42; i < 44; i++) begin
      acc(1, 0, 8'h47, {i[5:0], 2'b11}, 0);
      settle();
      `CHK(rsv, i == 43)
    end
    // delay measured from a rising input
    foreach (PC[j]) begin
      @(posedge sys_clk_in);
      dat <= 1'b0;
      acc(1, 0, 8'h45, 8'(PC[j]), 0);
      repeat (PC[j] * DIV + 2 * DIV + 4) @(posedge sys_clk_in);
      #1;
      `CHK(dly, 1'b0)
      @(posedge sys_clk_in);
      dat <= 1'b1;
      n = 0;
      while (dly !== 1'b1 && n < 700) begin
        settle();
        n++;
      end
      `CHK(n > PC[j] * DIV && n <= PC[j] * DIV + DIV, 1'b1)
    end
    repeat (4) @(posedge sys_clk_in);
    print_verdict();
  end
endmodule // adc_channel_config_regs_tb_top
